// [logic/acp_pkg.sv]
// shared constants for the converter bus port: pin layout, timing, host register map
// assumes a single 250 MHz core clock on both ends
package acp_pkg;
    // result and pin layout
    localparam int RES_W = 12;
    localparam int BUS_W = 12;
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam int BYTE_LSB = 4;
    localparam int JUST_BIT = 1;
    localparam int BSEL_BIT = 0;
    localparam int TIE_HI_LSB = 2;
    localparam int CTRL_W = 8;

    // timing, in ns as printed
    localparam int CLK_NS = 4;
    localparam int T_SC_NS = 50;
    localparam int T_CONV_MIN_NS = 3000;
    localparam int T_CONV_MAX_NS = 4400;
    localparam int T_CR_NS = 5000;
    localparam int T_CP_NS = 97;
    localparam int T_RP_NS = 97;
    localparam int T_FS_NS = 47;
    localparam int T_SD_MAX_NS = 400;

    // least times round up, longest times round down, never below one cycle
    function automatic int cyc_min(input int t_ns);
        int c;
        c = (t_ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_max(input int t_ns);
        int c;
        c = t_ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CONV_MIN_CYC = cyc_min(T_CONV_MIN_NS);
    localparam int CONV_MAX_CYC = cyc_max(T_CONV_MAX_NS);
    localparam int SC_CYC = cyc_min(T_SC_NS);
    localparam int CR_CYC = cyc_min(T_CR_NS);
    localparam int CP_CYC = cyc_min(T_CP_NS);
    localparam int RP_CYC = cyc_min(T_RP_NS);
    localparam int FS_CYC = cyc_min(T_FS_NS);
    localparam int SD_CYC = cyc_max(T_SD_MAX_NS);
    localparam int DONE_WAIT_CYC = cyc_max(T_CONV_MAX_NS + T_SD_MAX_NS);
    localparam int CNT_W = 11;
    localparam int TMR_W = 12;

    // host register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_RESULT = 4'h8;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_RIGHT_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_VALID_BIT = 1;
    localparam int ST_TIMEOUT_BIT = 2;
    localparam int ST_WIDE_BIT = 3;
endpackage

// [logic/acp_bus_if.sv]
// pin-level link between converter port and its bus controller
// assumes the bench drives both straps; released lines read high (pull-up or tie)
interface acp_bus_if import acp_pkg::*; ();
    logic sync_strap;
    logic width_strap;
    logic cs_n;
    logic conv_start_n;
    logic done_flag_enable_n;
    logic read_enable_n;
    logic done_o;
    logic done_oe_n;
    logic done_line;
    logic [BUS_W-1:0] dev_data_o;
    logic [BUS_W-1:0] dev_data_oe_n;
    logic [BUS_W-1:0] host_data_o;
    logic [BUS_W-1:0] host_data_oe_n;
    logic [BUS_W-1:0] result_bus;

    assign done_line = done_oe_n ? 1'b1 : done_o;
    assign result_bus = (~dev_data_oe_n & dev_data_o) | (~host_data_oe_n & host_data_o)
                        | (dev_data_oe_n & host_data_oe_n);

    modport device (
        input sync_strap, width_strap, cs_n, conv_start_n, done_flag_enable_n, read_enable_n, result_bus,
        output done_o, done_oe_n, dev_data_o, dev_data_oe_n
    );
    modport host (
        input sync_strap, width_strap, done_line, result_bus,
        output cs_n, conv_start_n, done_flag_enable_n, read_enable_n, host_data_o, host_data_oe_n
    );
endinterface

// [logic/acp_sync3.sv]
// three-stage input synchroniser with agreement filter
// assumes inputs come from outside the core clock domain
module acp_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // async in, filtered out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    wire [W-1:0] agree = ~(s2_reg ^ s3_reg);

    // a change is taken only once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q <= (agree & s3_reg) | (~agree & q);
        end
    end
endmodule

// [logic/acp_device.sv]
// converter end of the bus port: start gating, conversion timer, done pin, result drivers
// assumes host pins arrive asynchronously; the analog sample code comes from the user side
// Function
// R1: synchronous mode gates start and done by select
// R2: asynchronous mode ignores chip select entirely; the read drivers here still need select low in that mode
// R3: done low during conversion, high after
// R4: done three-state in sync, open-drain otherwise
// R5: done driven only while its enable low
// R6: read falling edge turns on result drivers
// R7: width strap picks word or byte output
// R8: bytes on upper lines; low lines are selects
// R9: byte select low gives high byte
// R10: justify high right-aligns, low left-aligns
// R11: host ignores lines 3,2 and ties high
// R12: host avoids reading during a conversion
// R13: conversion lasts 3.0 to 4.4 us
// R14: host starts at most every 5 us
// R15: host holds start low at least 97 ns
// R16: host read pulse at least 97 ns
// R17: host lowers select before the start strobe
// R18: twos complement bipolar, straight binary unipolar
// R19: right high byte zero or sign filled
// R20: result bus floats if select or read high
module acp_device import acp_pkg::*; #(
    parameter int CONV_CYCLES = CONV_MIN_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // pins
    acp_bus_if.device bus,
    // converter core side
    input wire logic [RES_W-1:0] sample_code,
    input wire logic bipolar_mode,
    output logic conv_busy,
    output logic conv_done_pulse,
    output logic [RES_W-1:0] result_word
);
    // sample_code is offset binary from the front end; bipolar output flips the msb
    function automatic logic [RES_W-1:0] encode(input logic [RES_W-1:0] code, input logic bip);
        logic [RES_W-1:0] r;
        r = code;
        if (bip) begin
            r[RES_W-1] = ~code[RES_W-1];
        end
        return r;
    endfunction

    function automatic logic [BYTE_W-1:0] fmt_byte(input logic [RES_W-1:0] r, input logic right,
                                                  input logic low_byte, input logic bip);
        logic [BYTE_W-1:0] b;
        b = '0;
        if (low_byte && right) begin
            b = r[BYTE_W-1:0];
        end else if (low_byte) begin
            b = {r[NIB_W-1:0], {NIB_W{1'b0}}};
        end else if (right) begin
            b = {(bip ? {NIB_W{r[RES_W-1]}} : {NIB_W{1'b0}}), r[RES_W-1:BYTE_W]};
        end else begin
            b = r[RES_W-1:NIB_W];
        end
        return b;
    endfunction

    logic [CTRL_W-1:0] pins_raw;
    logic [CTRL_W-1:0] pins_s;
    logic start_act_reg;
    logic read_act_reg;
    logic drv_on_reg;
    logic busy_reg;
    logic busy_next;
    logic done_pulse_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [RES_W-1:0] hold_reg;
    logic [RES_W-1:0] hold_next;
    logic [RES_W-1:0] result_reg;
    logic [RES_W-1:0] result_next;
    logic done_o_reg;
    logic done_oe_n_reg;
    logic [BUS_W-1:0] data_o_reg;
    logic [BUS_W-1:0] data_oe_n_reg;

    assign pins_raw = {bus.sync_strap, bus.width_strap, bus.cs_n, bus.conv_start_n,
                       bus.done_flag_enable_n, bus.read_enable_n,
                       bus.result_bus[JUST_BIT], bus.result_bus[BSEL_BIT]};

    acp_sync3 #(
        .W(CTRL_W),
        .RST_VAL({CTRL_W{1'b1}})
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(pins_raw),
        .q(pins_s)
    );

    wire sync_mode = pins_s[7];
    wire wide_mode = pins_s[6];
    wire cs_act = ~pins_s[5];
    wire start_low = ~pins_s[4];
    wire done_en_low = ~pins_s[3];
    wire read_low = ~pins_s[2];
    wire right_just = pins_s[1];
    wire low_byte = pins_s[0];

    // select qualifies only in synchronous mode
    wire gate_ok = cs_act | ~sync_mode; // see R1 see R2
    wire start_act = start_low & gate_ok; // see R1 see R2
    wire start_fall = start_act & ~start_act_reg;
    // a start while busy is ignored; the host is bound to the spacing anyway
    wire start_take = start_fall & ~busy_reg;
    wire conv_end = busy_reg && (cnt_reg == '0);

    // conversion timer, fixed length inside the documented window
    always_comb begin
        busy_next = busy_reg;
        cnt_next = cnt_reg;
        hold_next = hold_reg;
        result_next = result_reg;
        if (start_take) begin
            busy_next = 1'b1;
            cnt_next = CNT_W'(CONV_CYCLES - 1); // see R13
            hold_next = sample_code;
        end else if (conv_end) begin
            busy_next = 1'b0; // see R3
            result_next = encode(hold_reg, bipolar_mode); // see R18
        end else if (busy_reg) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    // done pin: level is not-busy, driver form follows the gating strap
    wire done_en = done_en_low & gate_ok; // see R5 see R1
    wire done_level = ~busy_reg; // see R3
    wire done_o_next = sync_mode ? done_level : 1'b0; // see R4
    wire done_oe_n_next = sync_mode ? ~done_en : ~(done_en & ~done_level); // see R4 see R5

    // result drivers
    wire read_act = cs_act & read_low;
    wire read_fall = read_act & ~read_act_reg;
    wire drv_on_next = read_act & (drv_on_reg | read_fall); // see R6 see R20
    wire [BYTE_W-1:0] byte_val = fmt_byte(result_reg, right_just, low_byte, bipolar_mode); // see R9 see R10 see R19
    wire [BUS_W-1:0] word_val = wide_mode ? result_reg : {byte_val, {BYTE_LSB{1'b0}}}; // see R7 see R8
    // narrow mode leaves the low four lines to the host as select inputs
    wire [BUS_W-1:0] drv_mask = wide_mode ? {BUS_W{1'b1}} : {{BYTE_W{1'b1}}, {BYTE_LSB{1'b0}}}; // see R8
    wire [BUS_W-1:0] oe_n_next = drv_on_next ? ~drv_mask : {BUS_W{1'b1}}; // see R6 see R20

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            start_act_reg <= 1'b0;
            read_act_reg <= 1'b0;
            drv_on_reg <= 1'b0;
            busy_reg <= 1'b0;
            cnt_reg <= '0;
            hold_reg <= '0;
            result_reg <= '0;
            done_pulse_reg <= 1'b0;
        end else begin
            start_act_reg <= start_act;
            read_act_reg <= read_act;
            drv_on_reg <= drv_on_next;
            busy_reg <= busy_next;
            cnt_reg <= cnt_next;
            hold_reg <= hold_next;
            result_reg <= result_next;
            done_pulse_reg <= conv_end;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            done_o_reg <= 1'b1;
            done_oe_n_reg <= 1'b1;
            data_o_reg <= '0;
            data_oe_n_reg <= '1;
        end else begin
            done_o_reg <= done_o_next;
            done_oe_n_reg <= done_oe_n_next;
            data_o_reg <= word_val & drv_mask;
            data_oe_n_reg <= oe_n_next;
        end
    end

    assign bus.done_o = done_o_reg;
    assign bus.done_oe_n = done_oe_n_reg;
    assign bus.dev_data_o = data_o_reg;
    assign bus.dev_data_oe_n = data_oe_n_reg;
    assign conv_busy = busy_reg;
    assign conv_done_pulse = done_pulse_reg;
    assign result_word = result_reg;
endmodule

// [logic/acp_host.sv]
// bus controller end: starts conversions, waits for done, reads the result as word or two bytes
// assumes the device end on the far side of acp_bus_if and a plain register port from software
module acp_host import acp_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // pins
    acp_bus_if.host bus,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_SETUP, ST_PULSE, ST_WAIT_LOW, ST_WAIT_HIGH, ST_RD_SETUP, ST_RD_PULSE, ST_FINISH
    } acp_hstate_t;

    acp_hstate_t state_reg;
    acp_hstate_t state_next;
    logic [TMR_W-1:0] tmr_reg;
    logic [TMR_W-1:0] tmr_next;
    logic [TMR_W-1:0] rate_reg;
    logic go_reg;
    logic right_reg;
    logic valid_reg;
    logic timeout_reg;
    logic second_reg;
    logic second_next;
    logic [BYTE_W-1:0] first_reg;
    logic [RES_W-1:0] result_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [BUS_W:0] in_raw;
    logic [BUS_W:0] in_s;

    assign in_raw = {bus.done_line, bus.result_bus};

    acp_sync3 #(
        .W(BUS_W + 1),
        .RST_VAL({(BUS_W + 1){1'b1}})
    ) u_in_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(in_raw),
        .q(in_s)
    );

    // straps are static board ties, read directly
    wire wide = bus.width_strap;
    wire done_s = in_s[BUS_W];
    wire [BYTE_W-1:0] byte_in = in_s[BUS_W-1:BYTE_LSB];
    wire tmr_zero = (tmr_reg == '0);
    wire wr_ctrl = reg_write && (reg_addr == REG_CTRL);
    wire wr_status = reg_write && (reg_addr == REG_STATUS);
    wire finishing = (state_reg == ST_FINISH);
    wire fail = (state_reg == ST_WAIT_LOW || state_reg == ST_WAIT_HIGH) && tmr_zero
                && (state_reg == ST_WAIT_HIGH ? !done_s : done_s);
    wire [RES_W-1:0] assembled = wide ? in_s[RES_W-1:0] :
                                 right_reg ? {first_reg[NIB_W-1:0], byte_in} :
                                 {first_reg, byte_in[BYTE_W-1:NIB_W]};

    always_comb begin
        state_next = state_reg;
        tmr_next = tmr_zero ? tmr_reg : tmr_reg - 1'b1;
        second_next = second_reg;
        case (state_reg)
            ST_IDLE: begin
                if (go_reg && rate_reg == '0) begin // see R14
                    state_next = ST_SETUP;
                    tmr_next = TMR_W'(SC_CYC - 1);
                end
            end
            ST_SETUP: begin
                if (tmr_zero) begin // see R17
                    state_next = ST_PULSE;
                    tmr_next = TMR_W'(CP_CYC - 1);
                end
            end
            ST_PULSE: begin
                if (tmr_zero) begin // see R15
                    state_next = ST_WAIT_LOW;
                    tmr_next = TMR_W'(SD_CYC - 1);
                end
            end
            ST_WAIT_LOW: begin
                if (!done_s) begin
                    state_next = ST_WAIT_HIGH;
                    tmr_next = TMR_W'(DONE_WAIT_CYC - 1);
                end else if (tmr_zero) begin
                    state_next = ST_FINISH;
                end
            end
            ST_WAIT_HIGH: begin
                if (done_s || tmr_zero) begin // see R12
                    state_next = done_s ? ST_RD_SETUP : ST_FINISH;
                    tmr_next = TMR_W'(FS_CYC - 1);
                    second_next = 1'b0;
                end
            end
            ST_RD_SETUP: begin
                if (tmr_zero) begin
                    state_next = ST_RD_PULSE;
                    tmr_next = TMR_W'(RP_CYC - 1);
                end
            end
            ST_RD_PULSE: begin
                if (tmr_zero) begin // see R16
                    tmr_next = TMR_W'(FS_CYC - 1);
                    second_next = 1'b1;
                    state_next = (wide || second_reg) ? ST_FINISH : ST_RD_SETUP;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    wire capture = (state_reg == ST_RD_PULSE) && tmr_zero && (wide || second_reg);
    wire pin_cs_n = (state_reg == ST_IDLE) || finishing;
    wire pin_start_n = (state_reg != ST_PULSE);
    wire pin_eoc_en_n = !(state_reg == ST_WAIT_LOW || state_reg == ST_WAIT_HIGH);
    wire pin_rd_n = (state_reg != ST_RD_PULSE);
    wire [BUS_W-1:0] sel_o = {{BYTE_W{1'b0}}, 2'b11, right_reg, second_reg}; // see R11
    wire [BUS_W-1:0] sel_oe_n = wide ? {BUS_W{1'b1}} : {{BYTE_W{1'b1}}, {BYTE_LSB{1'b0}}};

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            tmr_reg <= '0;
            second_reg <= 1'b0;
            first_reg <= '0;
            result_reg <= '0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            second_reg <= second_next;
            if ((state_reg == ST_RD_PULSE) && tmr_zero && !wide && !second_reg) begin
                first_reg <= byte_in;
            end
            if (capture) begin
                result_reg <= assembled;
            end
        end
    end

    // spacing counts from leaving idle, a fixed lead before the start strobe, so a rapid go still honours the period
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_reg <= '0;
        end else if (state_reg == ST_IDLE && state_next == ST_SETUP) begin
            rate_reg <= TMR_W'(CR_CYC - 1); // see R14
        end else if (rate_reg != '0) begin
            rate_reg <= rate_reg - 1'b1;
        end
    end

    // sticky flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            go_reg <= 1'b0;
            right_reg <= 1'b0;
            valid_reg <= 1'b0;
            timeout_reg <= 1'b0;
        end else begin
            go_reg <= (wr_ctrl && reg_wdata[CTRL_GO_BIT]) || (go_reg && state_next == ST_IDLE);
            if (wr_ctrl && state_reg == ST_IDLE) begin
                right_reg <= reg_wdata[CTRL_RIGHT_BIT];
            end
            valid_reg <= capture || (valid_reg && !(wr_status && reg_wdata[ST_VALID_BIT]));
            timeout_reg <= fail || (timeout_reg && !(wr_status && reg_wdata[ST_TIMEOUT_BIT]));
        end
    end

    wire [DATA_W-1:0] status_val = DATA_W'({wide, timeout_reg, valid_reg, (state_reg != ST_IDLE) || go_reg});
    wire [DATA_W-1:0] rd_mux = (reg_addr == REG_CTRL) ? DATA_W'({right_reg, 1'b0}) :
                               (reg_addr == REG_STATUS) ? status_val :
                               (reg_addr == REG_RESULT) ? DATA_W'(result_reg) : '0;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= reg_read ? rd_mux : '0;
        end
    end

    assign reg_rdata = rdata_reg;
    assign bus.cs_n = pin_cs_n;
    assign bus.conv_start_n = pin_start_n;
    assign bus.done_flag_enable_n = pin_eoc_en_n;
    assign bus.read_enable_n = pin_rd_n;
    assign bus.host_data_o = sel_o;
    assign bus.host_data_oe_n = sel_oe_n;
endmodule

// [tb/acp_port_chk.sv]
// wire-level checks on the converter bus port
// assumes one core clock and the signals of acp_bus_if as plain inputs
module acp_port_chk import acp_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // straps and host strobes
    input wire logic sync_strap,
    input wire logic width_strap,
    input wire logic cs_n,
    input wire logic conv_start_n,
    input wire logic done_flag_enable_n,
    input wire logic read_enable_n,
    // device drivers and resolved lines
    input wire logic done_o,
    input wire logic done_oe_n,
    input wire logic done_line,
    input wire logic [BUS_W-1:0] dev_data_oe_n,
    input wire logic [BUS_W-1:0] result_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // start-to-done timer; the pin sync lag is well inside the allowed span
    logic start_q_reg;
    logic done_q_reg;
    logic run_reg;
    logic [TMR_W-1:0] cnt_reg;
    wire logic start_fell = start_q_reg & ~conv_start_n;
    wire logic done_rose = ~done_q_reg & done_line;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            start_q_reg <= 1'b1;
            done_q_reg <= 1'b1;
            run_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            start_q_reg <= conv_start_n;
            done_q_reg <= done_line;
            if (start_fell) begin
                run_reg <= 1'b1;
                cnt_reg <= '0;
            end else if (done_rose) begin
                run_reg <= 1'b0;
            end else if (run_reg) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    chk_sync_done_gate: assert property ((sync_strap && cs_n) [*8] |-> done_oe_n)
        else $error("done driven while deselected in sync mode");
    chk_done_low_start: assert property ($fell(done_flag_enable_n) |-> ##[1:20] !done_line)
        else $error("done not low during conversion");
    chk_open_drain: assert property (!sync_strap && !done_oe_n |-> !done_o)
        else $error("open-drain done drove high");
    chk_done_enable: assert property (done_flag_enable_n [*8] |-> done_oe_n)
        else $error("done driven without enable");
    chk_wide_drive: assert property ((width_strap && !cs_n && !read_enable_n) [*8] |-> dev_data_oe_n == '0)
        else $error("word drivers not all on");
    chk_narrow_low_lines: assert property (!width_strap [*8] |-> &dev_data_oe_n[3:0])
        else $error("device drove select lines in byte mode");
    chk_right_fill: assert property ((!width_strap && !dev_data_oe_n[11] && result_bus[1:0] == 2'b10) [*8]
        |-> result_bus[11:8] inside {4'h0, {4{result_bus[7]}}})
        else $error("right high byte fill wrong");
    chk_conv_length: assert property (done_rose && run_reg |-> cnt_reg >= CONV_MIN_CYC && cnt_reg <= CONV_MAX_CYC)
        else $error("conversion length out of range");
    chk_bus_float: assert property ((cs_n || read_enable_n) [*8] |-> &dev_data_oe_n)
        else $error("result bus driven while not read");

    cov_wide_read: cover property (width_strap && !dev_data_oe_n[0]);
    cov_narrow_read: cover property (!width_strap && !dev_data_oe_n[11]);
    cov_async_done: cover property (!sync_strap && !done_oe_n);
endmodule

// [tb/adc_conversion_bus_port_tb.sv]
// self-checking bench: host and device joined over acp_bus_if, driven from the register port
// assumes the default conversion length and a 4 ns core clock
module adc_conversion_bus_port_tb;
    import acp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [RES_W-1:0] sample_code = '0;
    logic bipolar_mode = 1'b0;
    logic conv_busy;
    logic conv_done_pulse;
    logic [RES_W-1:0] result_word;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int n_done = 0;
    // codes chosen to hit sign boundary and mixed nibbles
    logic [RES_W-1:0] codes [4] = '{12'h123, 12'h9a5, 12'h800, 12'h7ff};

    always #2 core_clk = ~core_clk;

    acp_bus_if acp_bus_if_inst ();
    acp_device acp_device_inst (.core_clk(core_clk), .rst_b(rst_b), .bus(acp_bus_if_inst),
        .sample_code(sample_code), .bipolar_mode(bipolar_mode), .conv_busy(conv_busy),
        .conv_done_pulse(conv_done_pulse), .result_word(result_word));
    acp_host acp_host_inst (.core_clk(core_clk), .rst_b(rst_b), .bus(acp_bus_if_inst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    acp_port_chk acp_port_chk_inst (.core_clk(core_clk), .rst_b(rst_b),
        .sync_strap(acp_bus_if_inst.sync_strap), .width_strap(acp_bus_if_inst.width_strap),
        .cs_n(acp_bus_if_inst.cs_n), .conv_start_n(acp_bus_if_inst.conv_start_n),
        .done_flag_enable_n(acp_bus_if_inst.done_flag_enable_n), .read_enable_n(acp_bus_if_inst.read_enable_n),
        .done_o(acp_bus_if_inst.done_o), .done_oe_n(acp_bus_if_inst.done_oe_n),
        .done_line(acp_bus_if_inst.done_line), .dev_data_oe_n(acp_bus_if_inst.dev_data_oe_n),
        .result_bus(acp_bus_if_inst.result_bus));

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // sixteen conversions take about 22k cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t run timed out", $time);
            test_done();
        end
    end

    // one end-of-conversion pulse is expected per started conversion
    always @(posedge core_clk) begin
        if (conv_done_pulse === 1'b1)
            n_done <= n_done + 1;
    end

    task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 data = reg_rdata;
    endtask

    // index bits: 3 sync strap, 2 width strap, 1 justify right, 0 bipolar
    task automatic convert(input logic [3:0] i);
        logic [DATA_W-1:0] d;
        logic [RES_W-1:0] exp;
        int n;
        exp = codes[i[1:0]] ^ {i[0], 11'h000};
        @(posedge core_clk);
        acp_bus_if_inst.sync_strap <= i[3];
        acp_bus_if_inst.width_strap <= i[2];
        bipolar_mode <= i[0];
        sample_code <= codes[i[1:0]];
        repeat (20) @(posedge core_clk);
        wr(REG_CTRL, {30'h0, i[1], 1'b1});
        rd(REG_CTRL, d);
        cmp(d & 32'h2, {30'h0, i[1], 1'b0}, "justify");
        n = 0;
        d = '0;
        while (d[ST_VALID_BIT] !== 1'b1 && n < 3000) begin
            rd(REG_STATUS, d);
            n++;
        end
        cmp(d & 32'he, {28'h0, i[2], 3'b010}, "status");
        rd(REG_RESULT, d);
        cmp(d, {20'h0, exp}, "result");
        cmp({20'h0, result_word}, {20'h0, exp}, "word");
        cmp({31'h0, conv_busy}, 32'h0, "idle");
        cmp(32'(n_done), 32'(i) + 32'h1, "done pulses");
        wr(REG_STATUS, 32'h2);
        rd(REG_STATUS, d);
        cmp(d & 32'h2, 32'h0, "valid clear");
        rd(4'hc, d);
        cmp(d, 32'h0, "unmapped");
        // keeps start-to-start spacing above the minimum period
        repeat (500) @(posedge core_clk);
        $display("test %0d done", i);
    endtask

    initial begin
        logic [DATA_W-1:0] d;
        acp_bus_if_inst.sync_strap = 1'b1;
        acp_bus_if_inst.width_strap = 1'b1;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        wr(4'hc, 32'h3);
        rd(REG_CTRL, d);
        cmp(d, 32'h0, "unmapped write");
        for (int i = 0; i < 16; i++)
            convert(4'(i));
        test_done();
    end
endmodule
